// ==== hw/pfr_recorder.sv ====
// Fault event recorder: cycle counters, critical counters, record capture, AXI4-Lite registers
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

// Behaviour
// - time stamp holds 32-bit whole seconds
// - time stamp counts seconds since 1970 GMT
// - record keeps two-byte mains-loss cycle count
// - mains-loss cycles counted only while request asserted
// - record keeps two-byte request-driven cycle count
// - request cycles counted only with mains present
// - fault copies status and telemetry into record
// - snapshot order: status word, four bytes, readings
// - brief transients may be filtered out of snapshot
// - running critical totals saved in each record
// - critical counters saturate at fifteen
// - critical counts committed on every critical event
// - counter advances when its status bit asserts
// - held status bit counts only once
// - under-voltage count in lower half byte
// - then thermal, overcurrent, general, fan halves
// - record is 38 bytes, most recent event
module pfr_recorder
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Supply pins, asynchronous to CLK
  input wire logic MAINS_PRESENT,
  input wire logic POWER_ON_REQUEST_N,
  // Fault sources from supply logic on CLK
  input wire logic [4:0] CRIT_STATUS,
  input wire logic FAULT_EVENT,
  input wire pfr_pkg::pfr_snapshot_type SNAPSHOT,
  // Non-volatile commit strobes
  output logic NV_CRIT_COMMIT,
  output logic NV_RECORD_COMMIT,
  // AXI4-Lite write channels
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read channels
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // Pin synchronisers, first stage read only by second
  logic [1:0] mains_sync;
  logic [1:0] req_n_sync;
  logic mains_prev;                   // Previous synchronised mains level
  logic req_n_prev;                   // Previous synchronised request level
  logic mains_lost_armed;             // Mains dropped while request asserted
  logic req_off_armed;                // Request released while mains present
  logic [15:0] ac_cycles;             // Mains-loss power cycles
  logic [15:0] req_cycles;            // Request-driven power cycles
  logic [4:0] crit_prev;              // Last sampled critical status
  logic [4:0] crit_rise;              // First assertion of each critical bit
  pfr_pkg::pfr_crit_type crit_cnt;    // Running critical totals
  logic fault_prev;                   // Last sampled fault event input
  logic capture_pend;                 // Capture due next cycle
  logic [31:0] rtc;                   // Last written clock value
  logic [31:0] rec_words [0:pfr_pkg::REC_WORDS-1]; // Saved record
  logic record_valid;                 // A record has been captured
  logic [7:0] record_total;           // Records captured, saturating
  logic [8*4*pfr_pkg::REC_WORDS-1:0] next_record; // Record image being built
  // Write path state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_got;
  logic w_got;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic next_bvalid;
  logic next_rvalid;

  // Saturating four-bit increment
  function automatic logic [3:0] sat4(input logic [3:0] v, input logic hit);
    sat4 = (hit && v != pfr_pkg::CRIT_MAX) ? v + 4'h1 : v;
  endfunction

  // Saturating sixteen-bit increment
  function automatic logic [15:0] sat16(input logic [15:0] v, input logic hit);
    sat16 = (hit && v != pfr_pkg::CYCLE_MAX) ? v + 16'h0001 : v;
  endfunction

  // Byte-lane merge under write strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
  endfunction

  // Two-flop synchronisers for the asynchronous pins
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      mains_sync <= 2'h0;
      req_n_sync <= 2'h3;
    end
    else
    begin
      mains_sync <= {mains_sync[0], MAINS_PRESENT};
      req_n_sync <= {req_n_sync[0], POWER_ON_REQUEST_N};
    end
  end

  // Power cycle tracking; a cycle counts when the supply comes back on
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      mains_prev <= 1'b0;
      req_n_prev <= 1'b1;
      mains_lost_armed <= 1'b0;
      req_off_armed <= 1'b0;
      ac_cycles <= 16'h0000;
      req_cycles <= 16'h0000;
    end
    else
    begin
      mains_prev <= mains_sync[1];
      req_n_prev <= req_n_sync[1];
      // Mains falls while the request holds the supply on
      if (mains_prev && !mains_sync[1] && !req_n_sync[1])
        mains_lost_armed <= 1'b1;
      // Request released mid-outage: not a mains-loss cycle
      else if (req_n_sync[1])
        mains_lost_armed <= 1'b0;
      // Mains returns with the request still asserted
      else if (!mains_prev && mains_sync[1] && mains_lost_armed)
      begin
        mains_lost_armed <= 1'b0;
        ac_cycles <= sat16(ac_cycles, 1'b1);
      end
      // Request released while mains is present
      if (!req_n_prev && req_n_sync[1] && mains_sync[1])
        req_off_armed <= 1'b1;
      // Losing mains during the off time voids the cycle
      else if (!mains_sync[1])
        req_off_armed <= 1'b0;
      // Request asserted again with mains still present
      else if (req_n_prev && !req_n_sync[1] && req_off_armed)
      begin
        req_off_armed <= 1'b0;
        req_cycles <= sat16(req_cycles, 1'b1);
      end
    end
  end

  // Only the first assertion of a held status bit counts
  assign crit_rise = CRIT_STATUS & ~crit_prev;

  // Critical counters; a persisting bit is not counted again
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      crit_prev <= 5'h00;
      crit_cnt <= '0;
      NV_CRIT_COMMIT <= 1'b0;
    end
    else
    begin
      crit_prev <= CRIT_STATUS;
      crit_cnt.uv <= sat4(crit_cnt.uv, crit_rise[pfr_pkg::CRIT_UV]);
      crit_cnt.thermal <= sat4(crit_cnt.thermal, crit_rise[pfr_pkg::CRIT_THERM]);
      crit_cnt.ocp <= sat4(crit_cnt.ocp, crit_rise[pfr_pkg::CRIT_OCP]);
      crit_cnt.general <= sat4(crit_cnt.general, crit_rise[pfr_pkg::CRIT_GEN]);
      crit_cnt.fan <= sat4(crit_cnt.fan, crit_rise[pfr_pkg::CRIT_FAN]);
      // Counters are already updated when the strobe shows them
      NV_CRIT_COMMIT <= |crit_rise;
    end
  end

  // Record image, multi-byte fields low byte first
  always_comb
  begin
    next_record = '0;
    next_record[8*pfr_pkg::POS_RTC +: 32] = rtc;
    next_record[8*pfr_pkg::POS_AC +: 16] = ac_cycles;
    next_record[8*pfr_pkg::POS_REQ +: 16] = req_cycles;
    // Status bytes then readings, as the telemetry logic presents them
    next_record[8*pfr_pkg::POS_STATUS +: $bits(pfr_pkg::pfr_snapshot_type)] = SNAPSHOT;
    // Nibble order uv, thermal, ocp, general, fan, zero
    next_record[8*pfr_pkg::POS_CRIT +: 20] = crit_cnt;
  end

  // Capture one cycle after the event so the counts include it
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      fault_prev <= 1'b0;
      capture_pend <= 1'b0;
      record_valid <= 1'b0;
      record_total <= 8'h00;
      NV_RECORD_COMMIT <= 1'b0;
      for (int i = 0; i < pfr_pkg::REC_WORDS; i++)
        rec_words[i] <= 32'h0000_0000;
    end
    else
    begin
      fault_prev <= FAULT_EVENT;
      capture_pend <= (|crit_rise) | (FAULT_EVENT & ~fault_prev);
      NV_RECORD_COMMIT <= capture_pend;
      // Newest record replaces the old one
      if (capture_pend)
      begin
        record_valid <= 1'b1;
        record_total <= (record_total == 8'hFF) ? record_total : record_total + 8'h01;
        for (int i = 0; i < pfr_pkg::REC_WORDS; i++)
          rec_words[i] <= next_record[32*i +: 32];
      end
    end
  end

  // Write handshake, address and data taken in either order
  always_comb
  begin
    aw_got = aw_held | (S_AXI_AWVALID & S_AXI_AWREADY);
    w_got = w_held | (S_AXI_WVALID & S_AXI_WREADY);
    wr_fire = aw_got & w_got & ~S_AXI_BVALID;
    wr_addr = aw_held ? aw_addr : S_AXI_AWADDR;
    wr_data = w_held ? w_data : S_AXI_WDATA;
    wr_strb = w_held ? w_strb : S_AXI_WSTRB;
    next_bvalid = wr_fire | (S_AXI_BVALID & ~S_AXI_BREADY);
    next_rvalid = (S_AXI_ARVALID & S_AXI_ARREADY) | (S_AXI_RVALID & ~S_AXI_RREADY);
  end

  // Write channel state and the clock register
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= pfr_pkg::RESP_OKAY;
      rtc <= pfr_pkg::RTC_RESET;
    end
    else
    begin
      aw_held <= aw_got & ~wr_fire;
      w_held <= w_got & ~wr_fire;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
        aw_addr <= S_AXI_AWADDR;
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      // One write at a time: ready drops until the response is taken
      S_AXI_AWREADY <= ~(aw_got & ~wr_fire) & ~next_bvalid;
      S_AXI_WREADY <= ~(w_got & ~wr_fire) & ~next_bvalid;
      S_AXI_BVALID <= next_bvalid;
      if (wr_fire)
      begin
        // Only the clock register is writable; other mapped words ignore data
        if (wr_addr[7:2] == pfr_pkg::OFS_RTC[7:2])
        begin
          rtc <= merge(rtc, wr_data, wr_strb);
          S_AXI_BRESP <= pfr_pkg::RESP_OKAY;
        end
        else if (wr_addr[7:2] == pfr_pkg::OFS_STATUS[7:2] || wr_addr[7:2] == pfr_pkg::OFS_CYCLES[7:2] ||
                 wr_addr[7:2] == pfr_pkg::OFS_CRIT[7:2] ||
                 (wr_addr >= pfr_pkg::OFS_RECORD && wr_addr < pfr_pkg::OFS_RECORD + 8'h28))
          S_AXI_BRESP <= pfr_pkg::RESP_OKAY;
        // Holes in the map refuse the write
        else
          S_AXI_BRESP <= pfr_pkg::RESP_SLVERR;
      end
    end
  end

  // Read channel; data is looked up at the address handshake
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= pfr_pkg::RESP_OKAY;
    end
    else
    begin
      S_AXI_RVALID <= next_rvalid;
      S_AXI_ARREADY <= ~next_rvalid;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_RRESP <= pfr_pkg::RESP_OKAY;
        if (S_AXI_ARADDR[7:2] == pfr_pkg::OFS_STATUS[7:2])
          S_AXI_RDATA <= {16'h0000, record_total, 7'h00, record_valid};
        else if (S_AXI_ARADDR[7:2] == pfr_pkg::OFS_RTC[7:2])
          S_AXI_RDATA <= rtc;
        else if (S_AXI_ARADDR[7:2] == pfr_pkg::OFS_CYCLES[7:2])
          S_AXI_RDATA <= {req_cycles, ac_cycles};
        else if (S_AXI_ARADDR[7:2] == pfr_pkg::OFS_CRIT[7:2])
          S_AXI_RDATA <= {12'h000, crit_cnt};
        // Record words; the last holds two bytes, upper half zero
        else if (S_AXI_ARADDR >= pfr_pkg::OFS_RECORD && S_AXI_ARADDR < pfr_pkg::OFS_RECORD + 8'h28)
          S_AXI_RDATA <= rec_words[4'(S_AXI_ARADDR[7:2] - pfr_pkg::OFS_RECORD[7:2])];
        else
        begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= pfr_pkg::RESP_SLVERR;
        end
      end
    end
  end

endmodule // pfr_recorder

// ==== hw/pfr_pkg.sv ====
// Shared constants and types of the power-supply fault event recorder
package pfr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;   // Record state and event total
  localparam logic [7:0] OFS_RTC = 8'h04;      // Real-time clock, seconds since 1970 GMT
  localparam logic [7:0] OFS_CYCLES = 8'h08;   // Mains-loss count low half, request count high half
  localparam logic [7:0] OFS_CRIT = 8'h0C;     // Live packed critical counters
  localparam logic [7:0] OFS_RECORD = 8'h40;   // First word of the saved record
  localparam int REC_BYTES = 38;               // Bytes of one saved record
  localparam int REC_WORDS = 10;               // Words that hold one record
  // Reset value and saturation limits
  localparam logic [31:0] RTC_RESET = 32'h0000_0000;
  localparam logic [15:0] CYCLE_MAX = 16'hFFFF;       // Cycle counters stick here
  localparam logic [3:0] CRIT_MAX = 4'hF;             // Critical counters stick here
  // Byte positions inside the record
  localparam int POS_RTC = 3;        // Bytes 0..2 hold the on-time, kept at zero here
  localparam int POS_AC = 7;
  localparam int POS_REQ = 9;
  localparam int POS_STATUS = 11;
  localparam int POS_TELEM = 17;
  localparam int POS_CRIT = 33;
  // Critical status bit positions
  localparam int CRIT_UV = 0;        // Input under-voltage shutdown
  localparam int CRIT_THERM = 1;     // Thermal shutdown
  localparam int CRIT_OCP = 2;       // Over-current or over-power shutdown
  localparam int CRIT_GEN = 3;       // General failure shutdown
  localparam int CRIT_FAN = 4;       // Fan failure shutdown
  localparam int CRIT_N = 5;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status and telemetry snapshot, each field as presented by the telemetry logic
  typedef struct packed {
    logic [15:0] read_vout;
    logic [15:0] read_pin;
    logic [15:0] read_fan_speed;
    logic [15:0] read_temp_2;
    logic [15:0] read_temp_1;
    logic [15:0] read_iout;
    logic [15:0] read_iin;
    logic [15:0] read_vin;
    logic [7:0] status_fan;
    logic [7:0] status_temp;
    logic [7:0] status_input;
    logic [7:0] status_iout;
    logic [15:0] status_word;
  } pfr_snapshot_type;

  // Saturating critical shutdown counters
  typedef struct packed {
    logic [3:0] fan;
    logic [3:0] general;
    logic [3:0] ocp;
    logic [3:0] thermal;
    logic [3:0] uv;
  } pfr_crit_type;
endpackage

// ==== sim/pfr_recorder_chk.sv ====
// Bus and event timing checks of the fault event recorder
`timescale 1ns/100ps
module pfr_recorder_chk
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Event side
  input wire logic [4:0] CRIT_STATUS,
  input wire logic FAULT_EVENT,
  input wire logic NV_CRIT_COMMIT,
  input wire logic NV_RECORD_COMMIT,
  // Register bus
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID
);
  // One clock domain, so one default clocking and reset
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  wr_resp_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID)
    else $error("write response missing");
  rd_resp_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read response missing");
  aw_busy_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("second write accepted");
  ar_busy_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> !S_AXI_ARREADY)
    else $error("second read accepted");
  // Holes in the map answer with an error and zero data
  unmapped_err_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    && (S_AXI_ARADDR inside {[8'h10:8'h3C], [8'h68:8'hFF]})
    |=> S_AXI_RRESP == pfr_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
  rec_tail_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h64
    |=> S_AXI_RDATA == 32'h0)
    else $error("record tail not zero");
  crit_commit_a: assert property (|(CRIT_STATUS & ~$past(CRIT_STATUS)) |=> NV_CRIT_COMMIT)
    else $error("critical commit missing");
  held_bit_a: assert property (!(|(CRIT_STATUS & ~$past(CRIT_STATUS))) |=> !NV_CRIT_COMMIT)
    else $error("critical commit without new edge");
  rec_follow_a: assert property (NV_CRIT_COMMIT |=> NV_RECORD_COMMIT)
    else $error("record not saved after critical event");
  fault_rec_a: assert property ($rose(FAULT_EVENT) |-> ##2 NV_RECORD_COMMIT)
    else $error("record not saved after fault");
endmodule // pfr_recorder_chk

bind pfr_recorder pfr_recorder_chk u_chk (.CLK, .RESET, .CRIT_STATUS, .FAULT_EVENT, .NV_CRIT_COMMIT,
  .NV_RECORD_COMMIT, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID,
  .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID);

// ==== sim/pfr_supply_model.sv ====
// Supply pin model: mains presence and power-on request
`timescale 1ns/100ps
module pfr_supply_model
(
  // Pacing clock
  input wire logic clk,
  // Pins seen by the recorder
  output logic mains_present,
  output logic power_on_request_n
);
  // Starts powered, mains present and request asserted
  initial
  begin
    mains_present = 1'b1;
    power_on_request_n = 1'b0;
  end
  // A step lasts one 160 ns link period, long enough for the synchroniser to settle
  task automatic step(input logic m, input logic rn);
    @(posedge clk);
    mains_present <= m;
    power_on_request_n <= rn;
    repeat (32) @(posedge clk);
  endtask
endmodule // pfr_supply_model

// ==== sim/pfr_recorder_tb_top.sv ====
// Self-checking bench of the fault event recorder
`timescale 1ns/100ps
module pfr_recorder_tb_top;
  logic clk, reset, mains, req_n, fault, nv_crit, nv_rec;
  logic [4:0] crit;
  pfr_pkg::pfr_snapshot_type snap;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rtc_exp;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [1:0] b_seen; // Response of the last write
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [15:0] ac_exp, req_exp; // Expected cycle counts
  int errors, n_checks;
  int cnt [5]; // Expected critical totals

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  pfr_supply_model u_sup (.clk(clk), .mains_present(mains), .power_on_request_n(req_n));

  pfr_recorder u_dut (.CLK(clk), .RESET(reset), .MAINS_PRESENT(mains), .POWER_ON_REQUEST_N(req_n),
    .CRIT_STATUS(crit), .FAULT_EVENT(fault), .SNAPSHOT(snap), .NV_CRIT_COMMIT(nv_crit),
    .NV_RECORD_COMMIT(nv_rec), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A used-up wait counts as a mismatch and ends the run
  task automatic limit(input int n);
    if (n >= 200)
    begin
      errors++;
      conclude();
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!bvalid && n < 200);
    b_seen = bresp;
    bready <= 1'b0;
    limit(n);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!rvalid && n < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    limit(n);
  endtask

  task automatic test_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(pfr_pkg::OFS_RTC, d, r);
    chk("rtc reset", pfr_pkg::RTC_RESET, d);
    rtc_exp = 32'h5E0F_A1C3;
    wr(pfr_pkg::OFS_RTC, rtc_exp);
    chk("rtc write resp", {30'h0, pfr_pkg::RESP_OKAY}, {30'h0, b_seen});
    rd(pfr_pkg::OFS_RTC, d, r);
    chk("rtc readback", rtc_exp, d);
    rd(8'h20, d, r);
    chk("unmapped resp", {30'h0, pfr_pkg::RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    wr(8'h20, 32'h1234_5678);
    chk("unmapped write resp", {30'h0, pfr_pkg::RESP_SLVERR}, {30'h0, b_seen});
    rd(pfr_pkg::OFS_STATUS, d, r);
    chk("status empty", 32'h0, d);
    $display("test_regs done");
  endtask

  // Counted outage, counted request cycle, then both spoiled by the other pin
  task automatic test_cycles();
    logic [31:0] d;
    logic [1:0] r;
    u_sup.step(1'b0, 1'b0);
    u_sup.step(1'b1, 1'b0);
    u_sup.step(1'b1, 1'b1);
    u_sup.step(1'b1, 1'b0);
    u_sup.step(1'b0, 1'b1);
    u_sup.step(1'b1, 1'b1);
    u_sup.step(1'b1, 1'b0);
    // Outage cancelled by a release mid-outage must not count
    u_sup.step(1'b0, 1'b0);
    u_sup.step(1'b0, 1'b1);
    u_sup.step(1'b1, 1'b1);
    u_sup.step(1'b1, 1'b0);
    // Request cycle cancelled by a mains loss during the off time
    u_sup.step(1'b1, 1'b1);
    u_sup.step(1'b0, 1'b1);
    u_sup.step(1'b1, 1'b1);
    u_sup.step(1'b1, 1'b0);
    ac_exp = 16'h0001;
    req_exp = 16'h0001;
    rd(pfr_pkg::OFS_CYCLES, d, r);
    chk("cycle counts", {req_exp, ac_exp}, d);
    $display("test_cycles done");
  endtask

  // Status bit held for four cycles must count once
  task automatic pulse(input int i);
    @(posedge clk);
    crit <= 5'h01 << i;
    repeat (4) @(posedge clk);
    crit <= 5'h00;
    repeat (4) @(posedge clk);
    if (cnt[i] < 15) cnt[i]++;
  endtask

  task automatic test_crit();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 5; i++) pulse(i);
    repeat (17) pulse(0);
    rd(pfr_pkg::OFS_CRIT, d, r);
    chk("crit totals", {12'h0, 4'(cnt[4]), 4'(cnt[3]), 4'(cnt[2]), 4'(cnt[1]), 4'(cnt[0])}, d);
    wr(pfr_pkg::OFS_CRIT, 32'hFFFF_FFFF);
    chk("crit write resp", {30'h0, pfr_pkg::RESP_OKAY}, {30'h0, b_seen});
    rd(pfr_pkg::OFS_CRIT, d, r);
    chk("crit read only", {12'h0, 4'(cnt[4]), 4'(cnt[3]), 4'(cnt[2]), 4'(cnt[1]), 4'(cnt[0])}, d);
    $display("test_crit done");
  endtask

  task automatic test_record();
    logic [7:0] e [40];
    logic [31:0] d;
    logic [1:0] r;
    int n;
    for (int j = 0; j < 22; j++) snap[8*j +: 8] <= 8'hA0 + 8'(j);
    rtc_exp = 32'h6A5B_4C3D;
    wr(pfr_pkg::OFS_RTC, rtc_exp);
    @(posedge clk);
    fault <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!nv_rec && n < 200);
    fault <= 1'b0;
    limit(n);
    foreach (e[k]) e[k] = 8'h00;
    for (int k = 0; k < 4; k++) e[3+k] = rtc_exp[8*k +: 8];
    e[7] = ac_exp[7:0];
    e[8] = ac_exp[15:8];
    e[9] = req_exp[7:0];
    e[10] = req_exp[15:8];
    for (int j = 0; j < 22; j++) e[11+j] = 8'hA0 + 8'(j);
    e[33] = {4'(cnt[1]), 4'(cnt[0])};
    e[34] = {4'(cnt[3]), 4'(cnt[2])};
    e[35] = {4'h0, 4'(cnt[4])};
    for (int w = 0; w < pfr_pkg::REC_WORDS; w++)
    begin
      rd(pfr_pkg::OFS_RECORD + 8'(4*w), d, r);
      chk("record word", {e[4*w+3], e[4*w+2], e[4*w+1], e[4*w]}, d);
    end
    // 22 critical edges and one fault, each saving a record
    rd(pfr_pkg::OFS_STATUS, d, r);
    chk("status after records", {16'h0, 8'h17, 7'h0, 1'b1}, d);
    $display("test_record done");
  endtask

  initial
  begin
    reset = 1'b1;
    crit = 5'h00;
    fault = 1'b0;
    snap = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {errors, n_checks} = '0;
    foreach (cnt[i]) cnt[i] = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    test_regs();
    test_cycles();
    test_crit();
    test_record();
    conclude();
  end
endmodule // pfr_recorder_tb_top
